// ==== out4_map.svh ====
/*
 * Register addresses, reset values, response codes and divider defaults
 * for the output-four control block.
 * Assumes an 8-bit byte address on the register bus and 32-bit data.
 */
`ifndef OUT4_MAP_SVH
`define OUT4_MAP_SVH

// ============================================================
// register map
`define OUT4_CTRL_ADDR      8'h14
`define OUT4_STAT_ADDR      8'h18
`define OUT4_CTRL_RESET     8'h80
`define OUT4_WORD_PAD       24'h000000
`define OUT4_LOW_LANE       0

// ============================================================
// bus responses
`define OUT4_RESP_OKAY      2'h0
`define OUT4_RESP_SLVERR    2'h2

// ============================================================
// drive strength in milliamps
`define OUT4_MA_2           4'h2
`define OUT4_MA_4           4'h4
`define OUT4_MA_6           4'h6
`define OUT4_MA_8           4'h8

// ============================================================
// divider defaults: half period in reference edges plus a fraction
`define OUT4_DIV_INT        8'h04
`define OUT4_DIV_FRAC_NUM   8'h01
`define OUT4_DIV_FRAC_DEN   8'h03

`endif

// ==== out4_pkg.sv ====
/*
 * Types shared by the output-four control block: field layout of the
 * control byte, source and drive encodings, and the write request bundle.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package out4_pkg;

	// ============================================================
	// widths
	localparam int ADDR_W = 8;

	// ============================================================
	// field encodings
	typedef enum logic [1:0] {
		SRC_CRYSTAL,
		SRC_EXT_CLOCK,
		SRC_RESERVED,
		SRC_DIVIDER
	} source_t;

	typedef enum logic [1:0] {
		DRIVE_2MA,
		DRIVE_4MA,
		DRIVE_6MA,
		DRIVE_8MA
	} drive_t;

	// ============================================================
	// control byte, msb first
	typedef struct packed {
		logic    out4_power_down;
		logic    out4_divider_integer_mode;
		logic    out4_divider_reference_select;
		logic    out4_invert;
		source_t out4_source_select;
		drive_t  out4_drive_strength;
	} ctrl_t;

	// ============================================================
	// write request handed from the bus slave to the register file
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
	} wr_req_t;

endpackage

`default_nettype wire

// ==== out4_axil_slave.sv ====
/*
 * AXI4-Lite slave front end: takes write address and data in either order,
 * one write and one read at a time, and hands single-cycle strobes on.
 * Assumes the register file decodes combinationally and answers errors.
 */
`timescale 1ns/1ps
`default_nettype none
`include "out4_map.svh"

module out4_axil_slave (
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// write address and data channels
	input  wire logic [out4_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                          awvalid,
	output var  logic                          awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output var  logic                          wready,
	// write response channel
	output var  logic [1:0]                    bresp,
	output var  logic                          bvalid,
	input  wire logic                          bready,
	// read channels
	input  wire logic [out4_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                          arvalid,
	output var  logic                          arready,
	output var  logic [31:0]                   rdata,
	output var  logic [1:0]                    rresp,
	output var  logic                          rvalid,
	input  wire logic                          rready,
	// register file side
	output var  out4_pkg::wr_req_t             wr_req,
	output var  logic                          wr_en,
	input  wire logic                          wr_err,
	output var  logic                          rd_en,
	output var  logic [out4_pkg::ADDR_W-1:0]   rd_addr,
	input  wire logic [31:0]                   rd_data,
	input  wire logic                          rd_err
);

	logic              aw_got_r;
	logic              w_got_r;
	logic              bvalid_r;
	logic              rvalid_r;
	logic [1:0]        bresp_r;
	logic [1:0]        rresp_r;
	logic [31:0]       rdata_r;
	out4_pkg::wr_req_t req_r;

	// ============================================================
	// handshakes: each channel closes until its response is taken
	assign awready = !aw_got_r && !bvalid_r;
	assign wready  = !w_got_r && !bvalid_r;
	assign wr_en   = aw_got_r && w_got_r && !bvalid_r;
	assign wr_req  = req_r;
	assign arready = !rvalid_r;
	assign rd_en   = arvalid && arready;
	assign rd_addr = araddr;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;

	// write path: address and data latch independently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= `OUT4_RESP_OKAY;
			req_r    <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_got_r   <= 1'b1;
				req_r.addr <= awaddr;
			end else if (wr_en) begin
				aw_got_r <= 1'b0;
			end
			if (wvalid && wready) begin
				w_got_r    <= 1'b1;
				req_r.data <= wdata;
				req_r.strb <= wstrb;
			end else if (wr_en) begin
				w_got_r <= 1'b0;
			end
			if (wr_en) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_err ? `OUT4_RESP_SLVERR : `OUT4_RESP_OKAY;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read path: data captured in the cycle the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= `OUT4_RESP_OKAY;
			rdata_r  <= '0;
		end else if (rd_en) begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_err ? `OUT4_RESP_SLVERR : `OUT4_RESP_OKAY;
			rdata_r  <= rd_data;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== out4_frac_divider.sv ====
/*
 * Output divider for channel four: toggles its output every DIV_INT
 * reference edges, stretching a half period by one edge whenever the
 * fractional accumulator overflows.
 * Assumes ref_tick is a one-cycle pulse per reference rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "out4_map.svh"

module out4_frac_divider #(
	parameter int               INT_W    = 8,
	parameter logic [INT_W-1:0] DIV_INT  = `OUT4_DIV_INT,
	parameter logic [INT_W-1:0] FRAC_NUM = `OUT4_DIV_FRAC_NUM,
	parameter logic [INT_W-1:0] FRAC_DEN = `OUT4_DIV_FRAC_DEN
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic run,
	input  wire logic integer_mode,
	input  wire logic ref_tick,
	// divided clock and stretch marker
	output var  logic div_clk,
	output var  logic stretch
);

	logic [INT_W-1:0] cnt_r;
	logic [INT_W-1:0] acc_r;
	logic             div_clk_r;
	logic             extra_r;
	logic [INT_W:0]   acc_sum;
	logic             at_end;
	logic             overflow;
	logic             toggle;

	// ============================================================
	// half-period decision; integer mode never stretches
	assign acc_sum  = {1'b0, acc_r} + {1'b0, FRAC_NUM};
	assign at_end   = ref_tick && (cnt_r == DIV_INT - 1'b1);
	assign overflow = !integer_mode && !extra_r && (acc_sum >= {1'b0, FRAC_DEN});
	assign stretch  = at_end && overflow;
	assign toggle   = ref_tick && (extra_r || (at_end && !overflow));
	assign div_clk  = div_clk_r;

	// stopped divider holds everything cleared to save power
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r     <= '0;
			acc_r     <= '0;
			div_clk_r <= 1'b0;
			extra_r   <= 1'b0;
		end else begin
			if (toggle) begin
				div_clk_r <= ~div_clk_r;
				cnt_r     <= '0;
				extra_r   <= 1'b0;
			end else if (stretch) begin
				extra_r <= 1'b1;
			end else if (ref_tick) begin
				cnt_r <= cnt_r + 1'b1;
			end
			if (integer_mode) begin
				acc_r <= '0;
			end else if (at_end && !extra_r) begin
				acc_r <= overflow ? acc_sum[INT_W-1:0] - FRAC_DEN : acc_sum[INT_W-1:0];
			end
		end
	end

endmodule

`default_nettype wire

// ==== out4_control.sv ====
/*
 * Control register and output path for clock output four: the control
 * byte, a read-only status byte, source selection, inversion, power
 * down, drive strength and the output divider.
 * Assumes 10 MHz aclk, synchronous active-low reset, AXI4-Lite master,
 * and source clocks far slower than aclk (they are sampled as levels).
 */
// Behaviour
// - control bit 7 set powers the output driver down; clear keeps it up.
// - control bit 6 set forces integer divider mode; clear runs fractional.
// - control bit 5 picks the divider reference: first pll or second pll.
// - control bit 4 set inverts the output clock; clear passes it unchanged.
// - source field 00 routes the crystal oscillator straight to the output.
// - source field 01 routes the external clock input straight to the output.
// - source field 11 drives the output from the output divider.
// - drive field 00,01,10,11 gives 2, 4, 6 and 8 mA drive.
`timescale 1ns/1ps
`default_nettype none
`include "out4_map.svh"

module out4_control #(
	parameter int               INT_W    = 8,
	parameter logic [INT_W-1:0] DIV_INT  = `OUT4_DIV_INT,
	parameter logic [INT_W-1:0] FRAC_NUM = `OUT4_DIV_FRAC_NUM,
	parameter logic [INT_W-1:0] FRAC_DEN = `OUT4_DIV_FRAC_DEN
) (
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite write channels
	input  wire logic [out4_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                          awvalid,
	output var  logic                          awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output var  logic                          wready,
	output var  logic [1:0]                    bresp,
	output var  logic                          bvalid,
	input  wire logic                          bready,
	// axi4-lite read channels
	input  wire logic [out4_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                          arvalid,
	output var  logic                          arready,
	output var  logic [31:0]                   rdata,
	output var  logic [1:0]                    rresp,
	output var  logic                          rvalid,
	input  wire logic                          rready,
	// clock sources, asynchronous to aclk
	input  wire logic                          crystal_oscillator,
	input  wire logic                          external_clock_input,
	input  wire logic                          first_pll,
	input  wire logic                          second_pll,
	// output pin and driver settings
	output var  logic                          clock_output_four,
	output var  logic                          clock_output_four_en,
	output var  logic [3:0]                    out4_drive_ma
);

	localparam int ADDR_W   = out4_pkg::ADDR_W;
	localparam int NSRC     = 4;
	localparam int IDX_CRYSTAL_OSCILLATOR = 0;
	localparam int IDX_EXT  = 1;
	localparam int IDX_FIRST_PLL = 2;
	localparam int IDX_SECOND_PLL = 3;
	localparam logic [ADDR_W-1:0] CTRL_A = `OUT4_CTRL_ADDR;
	localparam logic [ADDR_W-1:0] STAT_A = `OUT4_STAT_ADDR;

	// ============================================================
	// decoding helpers
	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
	                                 input logic [ADDR_W-1:0] reg_a);
		addr_is = ({a[ADDR_W-1:2], 2'b00} == reg_a);
	endfunction

	function automatic logic [3:0] drive_ma(input out4_pkg::drive_t d);
		case (d)
			out4_pkg::DRIVE_2MA: drive_ma = `OUT4_MA_2;
			out4_pkg::DRIVE_4MA: drive_ma = `OUT4_MA_4;
			out4_pkg::DRIVE_6MA: drive_ma = `OUT4_MA_6;
			default:             drive_ma = `OUT4_MA_8;
		endcase
	endfunction

	// ============================================================
	// bus slave
	out4_pkg::wr_req_t      wr_req;
	logic                   wr_en;
	logic                   wr_err;
	logic                   rd_en;
	logic [ADDR_W-1:0]      rd_addr;
	logic [31:0]            rd_data;
	logic                   rd_err;

	out4_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_req  (wr_req),
		.wr_en   (wr_en),
		.wr_err  (wr_err),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// ============================================================
	// control register
	out4_pkg::ctrl_t ctrl_r;
	logic            wr_ctrl;
	logic            wr_stat;
	logic            rd_ctrl;
	logic            rd_stat;
	logic [7:0]      stat_byte;

	// status is read-only: a write to it is accepted and dropped
	assign wr_ctrl = wr_en && addr_is(wr_req.addr, CTRL_A);
	assign wr_stat = wr_en && addr_is(wr_req.addr, STAT_A);
	assign wr_err  = !addr_is(wr_req.addr, CTRL_A) && !addr_is(wr_req.addr, STAT_A);
	assign rd_ctrl = addr_is(rd_addr, CTRL_A);
	assign rd_stat = addr_is(rd_addr, STAT_A);
	assign rd_err  = !rd_ctrl && !rd_stat;
	assign rd_data = rd_ctrl ? {`OUT4_WORD_PAD, ctrl_r} :
	                 rd_stat ? {`OUT4_WORD_PAD, stat_byte} : '0;

	// only the low byte lane carries the control byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= out4_pkg::ctrl_t'(`OUT4_CTRL_RESET);
		end else if (wr_ctrl && wr_req.strb[`OUT4_LOW_LANE]) begin
			ctrl_r <= out4_pkg::ctrl_t'(wr_req.data[7:0]);
		end
	end

	// ============================================================
	// source synchronisers: three stages, change taken when 2 and 3 agree
	logic [NSRC-1:0] src_raw;
	logic [NSRC-1:0] s1_r;
	logic [NSRC-1:0] s2_r;
	logic [NSRC-1:0] s3_r;
	logic [NSRC-1:0] flt_r;
	logic [NSRC-1:0] flt_prev_r;
	logic [NSRC-1:0] rise;

	assign src_raw = {second_pll, first_pll, external_clock_input, crystal_oscillator};
	assign rise    = flt_r & ~flt_prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r       <= '0;
			s2_r       <= '0;
			s3_r       <= '0;
			flt_prev_r <= '0;
		end else begin
			s1_r       <= src_raw;
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			flt_prev_r <= flt_r;
		end
	end

	// a glitch shorter than one sample never reaches the filtered level
	for (genvar g = 0; g < NSRC; g++) begin : g_filter
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flt_r[g] <= 1'b0;
			end else if (s2_r[g] == s3_r[g]) begin
				flt_r[g] <= s3_r[g];
			end
		end
	end

	// ============================================================
	// output divider
	logic div_run;
	logic ref_tick;
	logic div_clk;
	logic div_stretch;

	// the divider only runs when it is routed out, to save power
	assign div_run  = !ctrl_r.out4_power_down
	                  && (ctrl_r.out4_source_select == out4_pkg::SRC_DIVIDER);
	assign ref_tick = ctrl_r.out4_divider_reference_select ? rise[IDX_SECOND_PLL]
	                                                       : rise[IDX_FIRST_PLL];

	// no delay offset exists here, so integer mode is always honoured
	out4_frac_divider #(
		.INT_W    (INT_W),
		.DIV_INT  (DIV_INT),
		.FRAC_NUM (FRAC_NUM),
		.FRAC_DEN (FRAC_DEN)
	) u_divider (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.run          (div_run),
		.integer_mode (ctrl_r.out4_divider_integer_mode),
		.ref_tick     (ref_tick),
		.div_clk      (div_clk),
		.stretch      (div_stretch)
	);

	// ============================================================
	// output path
	logic sel_level;
	logic reserved_sel;
	logic out_r;
	logic out_en_r;
	logic [3:0] drive_ma_r;

	// reserved code drives low rather than an undefined source
	assign reserved_sel = ctrl_r.out4_source_select == out4_pkg::SRC_RESERVED;
	assign sel_level =
		(ctrl_r.out4_source_select == out4_pkg::SRC_CRYSTAL)   ? flt_r[IDX_CRYSTAL_OSCILLATOR] :
		(ctrl_r.out4_source_select == out4_pkg::SRC_EXT_CLOCK) ? flt_r[IDX_EXT]  :
		(ctrl_r.out4_source_select == out4_pkg::SRC_DIVIDER)   ? div_clk : 1'b0;
	assign stat_byte = {drive_ma_r, div_clk, out_en_r, out_r, reserved_sel};

	// driver stage: power down parks the pin low and releases it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_r      <= 1'b0;
			out_en_r   <= 1'b0;
			drive_ma_r <= `OUT4_MA_2;
		end else begin
			out_r      <= !ctrl_r.out4_power_down && !reserved_sel
			              && (sel_level ^ ctrl_r.out4_invert);
			out_en_r   <= !ctrl_r.out4_power_down;
			drive_ma_r <= drive_ma(ctrl_r.out4_drive_strength);
		end
	end

	assign clock_output_four    = out_r;
	assign clock_output_four_en = out_en_r;
	assign out4_drive_ma        = drive_ma_r;

	// ============================================================
	// assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence ctrl_write_s;
		wr_ctrl && wr_req.strb[`OUT4_LOW_LANE];
	endsequence

	sequence live_s;
		!ctrl_r.out4_power_down && !ctrl_r.out4_invert;
	endsequence

	ctrl_write_a: assert property (ctrl_write_s |=> ctrl_r == $past(wr_req.data[7:0]))
		else $error("control byte not stored on write");

	stat_write_a: assert property (wr_stat |=> $stable(ctrl_r))
		else $error("status write changed the control byte");

	power_down_a: assert property (ctrl_r.out4_power_down |=>
		!clock_output_four && !clock_output_four_en)
		else $error("powered-down output still driven");

	integer_mode_a: assert property (ctrl_r.out4_divider_integer_mode |-> !div_stretch)
		else $error("integer mode stretched a period");

	ref_select_a: assert property (
		!ctrl_r.out4_divider_reference_select && rise[IDX_SECOND_PLL] && !rise[IDX_FIRST_PLL]
		|-> !ref_tick)
		else $error("divider clocked from unselected reference");

	invert_a: assert property (
		!ctrl_r.out4_power_down && !reserved_sel && ctrl_r.out4_invert
		|=> clock_output_four == !$past(sel_level))
		else $error("inverted output not inverted");

	crystal_route_a: assert property (
		live_s and ctrl_r.out4_source_select == out4_pkg::SRC_CRYSTAL
		|=> clock_output_four == $past(flt_r[IDX_CRYSTAL_OSCILLATOR]))
		else $error("crystal not routed to output");

	ext_route_a: assert property (
		live_s and ctrl_r.out4_source_select == out4_pkg::SRC_EXT_CLOCK
		|=> clock_output_four == $past(flt_r[IDX_EXT]))
		else $error("external clock not routed to output");

	reserved_low_a: assert property (reserved_sel |=> !clock_output_four)
		else $error("reserved source drove the output");

	divider_route_a: assert property (
		live_s and ctrl_r.out4_source_select == out4_pkg::SRC_DIVIDER
		|=> clock_output_four == $past(div_clk))
		else $error("divider not routed to output");

	drive_map_a: assert property (
		ctrl_r.out4_drive_strength == out4_pkg::DRIVE_8MA ##1
		$stable(ctrl_r.out4_drive_strength) |-> out4_drive_ma == `OUT4_MA_8)
		else $error("drive strength decode wrong");

endmodule

`default_nettype wire

// ==== test_out4_control.sv ====
/*
 * Self-checking bench for the output-four control block: register access
 * over AXI4-Lite, source routing, inversion, power down, drive strength
 * and the output divider.
 * Assumes out4_control with its package and map header, a 10 MHz aclk
 * and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "out4_map.svh"

module test_clock_output_four_control;

	// ============================================================
	// design ports and bench state
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, c;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb, out4_drive_ma;
	logic [1:0]  bresp, rresp;
	logic        crystal_oscillator, external_clock_input, first_pll, second_pll;
	logic        clock_output_four, clock_output_four_en, out_prev;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	logic [33:0] rexp;
	int          n_mismatch, n_checks, tog, i, t0;
	logic [7:0]  modes[3] = '{8'h4c, 8'h0c, 8'h6c};
	int          n_tog[3] = '{6, 5, 3};

	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end

	out4_control #(.DIV_INT(8'h04)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.crystal_oscillator(crystal_oscillator), .external_clock_input(external_clock_input),
		.first_pll(first_pll), .second_pll(second_pll),
		.clock_output_four(clock_output_four), .clock_output_four_en(clock_output_four_en),
		.out4_drive_ma(out4_drive_ma)
	);

	// ============================================================
	// comparison and closing
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// a lost handshake counts against the run and stops it
	task automatic hung;
		check("handshake", 32'h0, 32'h1);
		finish_test();
	endtask

	// ============================================================
	// bus master: each task starts one edge later, so no signal is set twice
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		@(posedge aclk);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		if (n == 40) hung();
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
		int n;
		@(posedge aclk);
		rq.push_back({r, d});
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		if (n == 40) hung();
	endtask

	// second pll rises on every other first pll rise, so the two counts differ
	task automatic pulses(input int k);
		repeat (k) begin
			first_pll <= 1'h1;
			second_pll <= ~second_pll;
			repeat (8) @(posedge aclk);
			first_pll <= 1'h0;
			repeat (8) @(posedge aclk);
		end
	endtask

	// ============================================================
	// response monitor: oldest note against each handshake
	always @(posedge aclk) begin
		out_prev <= clock_output_four;
		if (clock_output_four !== out_prev) tog <= tog + 1;
		if (bvalid && bready) check("bresp", 32'(bresp), 32'(bq.pop_front()));
		if (rvalid && rready) begin
			rexp = rq.pop_front();
			check("rresp", 32'(rresp), 32'(rexp[33:32]));
			check("rdata", rdata, rexp[31:0]);
		end
	end

	// ============================================================
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{crystal_oscillator, external_clock_input, first_pll, second_pll} = 4'h0;
		void'($urandom(32'h5e1ea8d6));
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		check("en", 32'(clock_output_four_en), 32'h0);
		rd(`OUT4_CTRL_ADDR, `OUT4_RESP_OKAY, 32'h80);
		$display("test reset done");
		// random levels, source, invert; drive walks all four codes
		for (i = 0; i < 8; i++) begin
			v = $urandom;
			crystal_oscillator <= v[0];
			external_clock_input <= v[1];
			c = {3'h0, v[2], 1'h0, v[3], 2'(i)};
			wr(`OUT4_CTRL_ADDR, {v[31:8], c}, 4'hf, `OUT4_RESP_OKAY);
			repeat (8) @(posedge aclk);
			check("out", 32'(clock_output_four), 32'((v[3] ? v[1] : v[0]) ^ v[2]));
			check("en", 32'(clock_output_four_en), 32'h1);
			check("drive", 32'(out4_drive_ma), 32'(2 * (i % 4 + 1)));
			rd(`OUT4_CTRL_ADDR, `OUT4_RESP_OKAY, {24'h0, c});
		end
		$display("test routing done");
		// reserved source, then power down with a live source
		crystal_oscillator <= 1'h1;
		wr(`OUT4_CTRL_ADDR, 32'h08, 4'hf, `OUT4_RESP_OKAY);
		repeat (8) @(posedge aclk);
		check("out", 32'(clock_output_four), 32'h0);
		rd(`OUT4_STAT_ADDR, `OUT4_RESP_OKAY, 32'h25);
		wr(`OUT4_CTRL_ADDR, 32'h80, 4'hf, `OUT4_RESP_OKAY);
		repeat (4) @(posedge aclk);
		check("out", 32'(clock_output_four), 32'h0);
		check("en", 32'(clock_output_four_en), 32'h0);
		// masked write, unmapped place
		wr(`OUT4_CTRL_ADDR, 32'h0c, 4'h0, `OUT4_RESP_OKAY);
		rd(`OUT4_CTRL_ADDR, `OUT4_RESP_OKAY, 32'h80);
		// status is read-only: the write is accepted and dropped
		wr(`OUT4_STAT_ADDR, 32'hff, 4'hf, `OUT4_RESP_OKAY);
		rd(`OUT4_CTRL_ADDR, `OUT4_RESP_OKAY, 32'h80);
		wr(8'h40, 32'h0, 4'hf, `OUT4_RESP_SLVERR);
		rd(8'h40, `OUT4_RESP_SLVERR, 32'h0);
		$display("test refusal done");
		// divider: integer, fractional, second pll reference
		for (i = 0; i < 3; i++) begin
			wr(`OUT4_CTRL_ADDR, 32'h80, 4'hf, `OUT4_RESP_OKAY);
			wr(`OUT4_CTRL_ADDR, {24'h0, modes[i]}, 4'hf, `OUT4_RESP_OKAY);
			repeat (8) @(posedge aclk);
			t0 = tog;
			pulses(24);
			repeat (16) @(posedge aclk);
			check("toggles", 32'(tog - t0), 32'(n_tog[i]));
		end
		$display("test divider done");
		// reset in mid-run returns the control byte to powered down
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		check("en", 32'(clock_output_four_en), 32'h0);
		rd(`OUT4_CTRL_ADDR, `OUT4_RESP_OKAY, 32'h80);
		$display("test second reset done");
		finish_test();
	end

endmodule
`default_nettype wire
